// file: logic/fbr_pkg.sv
/*
  shared constants and types for the flash burst read engine.
  assumes 16-bit words, 24-bit word address, 16 banks on the top bits.
*/
package fbr_pkg;
  localparam int ADDR_W     = 24;
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int LINE_BITS  = 7;   // 128-word line
  localparam int BANK_LSB   = 20;  // bank = address[23:20]
  // configuration word after power-up or hardware reset
  localparam logic [15:0] CFG_RESET = 16'hafc8;
  // initial latency codes and the edge on which first data is valid
  localparam logic [2:0] LAT_5   = 3'h3;
  localparam logic [2:0] LAT_6   = 3'h4;
  localparam logic [2:0] LAT_7   = 3'h5;
  localparam logic [2:0] EDGES_5 = 3'h5;
  localparam logic [2:0] EDGES_6 = 3'h6;
  localparam logic [2:0] EDGES_7 = 3'h7;
  // burst length codes and word counts
  localparam logic [2:0] BL_CONT = 3'h0;
  localparam logic [2:0] BL_8    = 3'h2;
  localparam logic [2:0] BL_16   = 3'h3;
  localparam logic [2:0] BL_32   = 3'h4;
  localparam logic [5:0] LEN_8   = 6'h08;
  localparam logic [5:0] LEN_16  = 6'h10;
  localparam logic [5:0] LEN_32  = 6'h20;

  typedef struct packed {
    logic       read_mode_select_bit;
    logic       high_density_wait_bit;
    logic [2:0] initial_latency_field;
    logic [6:0] ready_cfg_bits;
    logic       wrap_enable_bit;
    logic [2:0] burst_length_field;
  } fbr_cfg_s;

  // host pins as one sampled group
  typedef struct packed {
    logic              cs_n;
    logic              avd_n;
    logic              bclk;
    logic [ADDR_W-1:0] addr;
  } fbr_pins_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LATENCY, ST_BURST, ST_GAP, ST_STATUS, ST_DONE
  } fbr_state_e;
endpackage : fbr_pkg

// file: logic/fbr_burst_engine.sv
/*
  burst read engine with configuration register and prefetch fifo.
  assumes host pins are asynchronous to clock and that the array returns
  a word the cycle after array_req; bank_busy comes from the write engine.
*/
`timescale 1ns/1ps

// prefetch buffer between array and burst output
module fbr_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic                 clock,     // core clock
  input  wire logic                 rst_n,     // async reset
  input  wire logic                 flush,     // drop all words
  input  wire logic                 in_valid,  // push request
  output logic                      in_ready,  // room left
  input  wire logic [W-1:0]         in_data,   // pushed word
  output logic                      out_valid, // word available
  input  wire logic                 out_ready, // pop request
  output logic [W-1:0]              out_data,  // head word
  output logic [$clog2(D):0]        count      // words held
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]   next_count;
  logic          push, pop;

  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  // pointer and count update, flush wins
  always_comb begin
    next_wr_ptr = flush ? '0 : wr_ptr + AW'(push);
    next_rd_ptr = flush ? '0 : rd_ptr + AW'(pop);
    next_count  = flush ? '0 : count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage carries no reset
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : fbr_fifo

//
// Contract
// - continuous burst counts upward and rolls from top address to zero
// - continuous burst ends only on chip select high or reset
// - address_valid_n low with new address restarts the access
// - crossing a 128-word line inserts one wait edge; the code inserts none when the next word's bank is busy
// - burst into busy bank outputs status and ignores further edges
// - wrap burst reads 8/16/32 words inside its aligned group
// - wrap burst never inserts line-crossing waits
// - non-wrap linear burst outputs 8/16/32 words then stops
// - non-wrap linear burst gets the line-crossing wait
// - reset selects asynchronous mode and default configuration
// - configuration survives chip select going high
// - configuration word is readable back
// - read_mode_select_bit 0 synchronous, 1 asynchronous, default 1
// - latency codes 011/100/101 give data on edge 5/6/7
// - initial wait edges come before the first word
// - wrap_enable_bit 1 wraps linear bursts, ignored when continuous
// - length codes 000 continuous, 010/011/100 give 8/16/32 words
// - ready marks each valid word, low during waits
module fbr_burst_engine (
  input  wire logic        clock,           // core clock, 250 MHz
  input  wire logic        rst_n,           // hardware reset, async
  input  wire logic        chip_select_n,   // host chip select pin
  input  wire logic        address_valid_n, // host address strobe pin
  input  wire logic        burst_clk,       // host burst clock pin
  input  wire logic [23:0] address,         // host address pins
  input  wire logic        cfg_write,       // set-configuration strobe
  input  wire logic [15:0] cfg_wdata,       // new configuration word
  input  wire logic [15:0] bank_busy,       // bank programming/erasing
  input  wire logic [15:0] status_word,     // status shown on busy bank
  input  wire logic [15:0] array_data,      // word, cycle after request
  output logic      [23:0] array_addr,      // array fetch address
  output logic             array_req,       // array fetch pulse
  output logic      [15:0] data_out,        // burst data pins
  output logic             ready,           // data valid on pins
  output logic      [15:0] cfg_rdata,       // configuration read-back
  output logic             async_mode       // 1 while asynchronous
);
  fbr_pkg::fbr_pins_s  pin_s1, pin_s2, pin_s3, pin_in;
  fbr_pkg::fbr_cfg_s   cfg, next_cfg;
  fbr_pkg::fbr_state_e state, next_state;
  logic [23:0] out_addr, next_out_addr, adv_addr;
  logic [23:0] next_array_addr, fetch_addr, next_fetch_addr;
  logic [5:0]  word_cnt, next_word_cnt, fetch_cnt, next_fetch_cnt;
  logic [5:0]  len;
  logic [2:0]  lat_cnt, next_lat_cnt, lat_edges;
  logic [15:0] next_data_out;
  logic        next_ready, next_array_req, req_q, next_req_q;
  logic        fetch_on, next_fetch_on, edge_p, flush, pop, wrap_lin;
  logic        do_emit, fifo_in_ready, fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic [3:0]  fifo_count;

  // words in a linear burst, zero for continuous
  function automatic logic [5:0] burst_len(input logic [2:0] code);
    case (code)
      fbr_pkg::BL_8:  burst_len = fbr_pkg::LEN_8;
      fbr_pkg::BL_16: burst_len = fbr_pkg::LEN_16;
      fbr_pkg::BL_32: burst_len = fbr_pkg::LEN_32;
      default:        burst_len = 6'h00;
    endcase
  endfunction : burst_len

  // next word address, confined to the aligned group when wrapping
  function automatic logic [23:0] next_addr(input logic [23:0] a,
                                            input logic [5:0]  n,
                                            input logic        wrap);
    logic [23:0] mask;
    mask = {18'h00000, n} - 24'h000001;
    if (wrap)
      next_addr = (a & ~mask) | ((a + 24'h000001) & mask);
    else
      next_addr = a + 24'h000001;
  endfunction : next_addr

  assign pin_in    = '{cs_n: chip_select_n, avd_n: address_valid_n,
                       bclk: burst_clk, addr: address};
  assign edge_p    = pin_s2.bclk && !pin_s3.bclk;
  assign len       = burst_len(cfg.burst_length_field);
  assign wrap_lin  = cfg.wrap_enable_bit && (len != 6'h00);
  assign adv_addr  = next_addr(out_addr, len, wrap_lin);
  assign cfg_rdata = cfg;
  assign async_mode = cfg.read_mode_select_bit;

  always_comb begin
    case (cfg.initial_latency_field)
      fbr_pkg::LAT_5: lat_edges = fbr_pkg::EDGES_5;
      fbr_pkg::LAT_6: lat_edges = fbr_pkg::EDGES_6;
      default:        lat_edges = fbr_pkg::EDGES_7;
    endcase
  end

  // pins pass two flops; third stage only for edge finding
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '{cs_n: 1'b1, avd_n: 1'b1, bclk: 1'b0, addr: 24'h000000};
      pin_s2 <= '{cs_n: 1'b1, avd_n: 1'b1, bclk: 1'b0, addr: 24'h000000};
      pin_s3 <= '{cs_n: 1'b1, avd_n: 1'b1, bclk: 1'b0, addr: 24'h000000};
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // configuration kept across chip select, only reset restores it
  always_comb begin
    next_cfg = cfg_write ? fbr_pkg::fbr_cfg_s'(cfg_wdata) : cfg;
  end

  // burst sequencer, acts once per burst clock rising edge
  always_comb begin
    next_state    = state;
    next_lat_cnt  = lat_cnt;
    next_out_addr = out_addr;
    next_word_cnt = word_cnt;
    next_data_out = data_out;
    next_ready    = ready;
    flush         = 1'b0;
    pop           = 1'b0;
    do_emit       = 1'b0;
    // chip select high ends the burst even with the burst clock parked
    if (pin_s2.cs_n) begin
      next_state = fbr_pkg::ST_IDLE;
      next_ready = 1'b0;
    end else if (edge_p) begin
      if (!pin_s2.avd_n) begin
        flush         = 1'b1;
        next_out_addr = pin_s2.addr;
        next_word_cnt = 6'h00;
        next_lat_cnt  = 3'h0;
        next_ready    = 1'b0;
        next_state    = cfg.read_mode_select_bit ? fbr_pkg::ST_IDLE
                                                 : fbr_pkg::ST_LATENCY;
      end else begin
        case (state)
          fbr_pkg::ST_LATENCY: begin
            next_lat_cnt = lat_cnt + 3'h1;
            do_emit      = (next_lat_cnt == lat_edges);
          end
          fbr_pkg::ST_BURST: begin
            do_emit = 1'b1;
          end
          fbr_pkg::ST_GAP: begin
            next_ready = 1'b0;
            next_state = fbr_pkg::ST_BURST;
          end
          fbr_pkg::ST_DONE: begin
            next_ready = 1'b0;
          end
          default: begin
            next_state = state;
          end
        endcase
        if (do_emit) begin
          if (bank_busy[out_addr[23:fbr_pkg::BANK_LSB]]) begin
            next_data_out = status_word;
            next_ready    = 1'b1;
            next_state    = fbr_pkg::ST_STATUS;
          end else if (fifo_out_valid) begin
            pop           = 1'b1;
            next_data_out = fifo_out_data;
            next_ready    = 1'b1;
            next_out_addr = adv_addr;
            next_word_cnt = word_cnt + 6'h01;
            if (len != 6'h00 && next_word_cnt == len)
              next_state = fbr_pkg::ST_DONE;
            else if (!wrap_lin &&
                     adv_addr[fbr_pkg::LINE_BITS-1:0] == 7'h00 &&
                     !bank_busy[adv_addr[23:fbr_pkg::BANK_LSB]])
              next_state = fbr_pkg::ST_GAP;
            else
              next_state = fbr_pkg::ST_BURST;
          end else begin
            next_ready = 1'b0;
            next_state = fbr_pkg::ST_BURST;
          end
        end
      end
    end
  end

  // prefetch: keep the fifo topped up without overrunning it
  always_comb begin
    next_fetch_on   = fetch_on;
    next_fetch_addr = fetch_addr;
    next_fetch_cnt  = fetch_cnt;
    next_array_req  = 1'b0;
    next_array_addr = array_addr;
    next_req_q      = array_req && !flush;
    if (pin_s2.cs_n) begin
      next_fetch_on = 1'b0;
    end
    if (flush) begin
      next_fetch_on   = !cfg.read_mode_select_bit;
      next_fetch_addr = pin_s2.addr;
      next_fetch_cnt  = 6'h00;
    end else if (fetch_on && fifo_in_ready &&
                 (fifo_count + 4'(array_req) + 4'(req_q)) <
                 4'(fbr_pkg::FIFO_DEPTH) &&
                 (len == 6'h00 || fetch_cnt < len)) begin
      next_array_req  = 1'b1;
      next_array_addr = fetch_addr;
      next_fetch_addr = next_addr(fetch_addr, len, wrap_lin);
      next_fetch_cnt  = fetch_cnt + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg        <= fbr_pkg::fbr_cfg_s'(fbr_pkg::CFG_RESET);
      state      <= fbr_pkg::ST_IDLE;
      lat_cnt    <= 3'h0;
      out_addr   <= 24'h000000;
      word_cnt   <= 6'h00;
      data_out   <= 16'h0000;
      ready      <= 1'b0;
      fetch_on   <= 1'b0;
      fetch_addr <= 24'h000000;
      fetch_cnt  <= 6'h00;
      array_req  <= 1'b0;
      array_addr <= 24'h000000;
      req_q      <= 1'b0;
    end else begin
      cfg        <= next_cfg;
      state      <= next_state;
      lat_cnt    <= next_lat_cnt;
      out_addr   <= next_out_addr;
      word_cnt   <= next_word_cnt;
      data_out   <= next_data_out;
      ready      <= next_ready;
      fetch_on   <= next_fetch_on;
      fetch_addr <= next_fetch_addr;
      fetch_cnt  <= next_fetch_cnt;
      array_req  <= next_array_req;
      array_addr <= next_array_addr;
      req_q      <= next_req_q;
    end
  end

  fbr_fifo #(.W(fbr_pkg::DATA_W), .D(fbr_pkg::FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (req_q),
    .in_ready  (fifo_in_ready),
    .in_data   (array_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  // checks on the sequencer
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_CONT_INCR: assert property (pop && len == 6'h00 |=>
    out_addr == $past(out_addr) + 24'h000001)
    else $error("continuous address did not step by one");
  AST_CS_ENDS: assert property (pin_s2.cs_n |=>
    state == fbr_pkg::ST_IDLE && !ready)
    else $error("chip select high did not end burst");
  AST_RESTART: assert property (edge_p && !pin_s2.cs_n && !pin_s2.avd_n
    |=> out_addr == $past(pin_s2.addr) && word_cnt == 6'h00)
    else $error("new address did not restart burst");
  AST_LINE_GAP: assert property (pop && !wrap_lin &&
    adv_addr[6:0] == 7'h00 && !(len != 6'h00 && next_word_cnt == len) &&
    !bank_busy[adv_addr[23:fbr_pkg::BANK_LSB]]
    |=> state == fbr_pkg::ST_GAP)
    else $error("line crossing without wait edge");
  AST_BUSY: assert property (do_emit &&
    bank_busy[out_addr[23:fbr_pkg::BANK_LSB]] |=>
    data_out == $past(status_word) && state == fbr_pkg::ST_STATUS)
    else $error("busy bank did not give status");
  AST_STATUS_HOLD: assert property (state == fbr_pkg::ST_STATUS &&
    !pin_s2.cs_n && !(edge_p && !pin_s2.avd_n) |=> $stable(data_out)
    && state == fbr_pkg::ST_STATUS)
    else $error("status burst reacted to clock");
  AST_WRAP_GROUP: assert property (pop && wrap_lin |=>
    (out_addr & ~({18'h00000, len} - 24'h000001)) ==
    ($past(out_addr) & ~({18'h00000, len} - 24'h000001)))
    else $error("wrap burst left its group");
  AST_NO_GAP_WRAP: assert property (wrap_lin &&
    state != fbr_pkg::ST_GAP |=> state != fbr_pkg::ST_GAP)
    else $error("wrap burst inserted a line wait");
  AST_LEN: assert property (state == fbr_pkg::ST_DONE |->
    word_cnt == len)
    else $error("linear burst length wrong");
  AST_CFG_HOLD: assert property (!cfg_write |=> $stable(cfg))
    else $error("configuration changed without write");
  AST_FIRST_WORD: assert property (state == fbr_pkg::ST_LATENCY && pop
    |-> next_lat_cnt == lat_edges)
    else $error("first word on wrong edge");
  AST_EARLY_WAIT: assert property (state == fbr_pkg::ST_LATENCY &&
    edge_p && !pin_s2.cs_n && pin_s2.avd_n &&
    lat_cnt + 3'h1 != lat_edges |=> !ready)
    else $error("word shown before the initial wait edges");
  AST_READY_EDGE: assert property ($rose(ready) |-> $past(edge_p))
    else $error("ready rose away from a clock edge");

  COV_CONT: cover property (pop && len == 6'h00);
  COV_GAP: cover property (state == fbr_pkg::ST_GAP);
  COV_WRAP_DONE: cover property (wrap_lin && state == fbr_pkg::ST_DONE);
  COV_STATUS: cover property (state == fbr_pkg::ST_STATUS);
endmodule : fbr_burst_engine

// file: tb/fbr_host_model.sv
/*
  host controller model: drives chip select, address strobe, address and
  the burst clock, and records ready and data late in the high phase of each burst period.
  assumes the engine settles its pins within 14 ns of a burst clock rising edge.
*/
`timescale 1ns/1ps

module fbr_host_model (
  output logic             chip_select_n,   // chip select pin
  output logic             address_valid_n, // address strobe pin
  output logic             burst_clk,       // 32 ns, still between frames
  output logic      [23:0] address,         // address pins
  input  wire logic [15:0] data_out,        // burst data from engine
  input  wire logic        ready            // data valid from engine
);
  logic        q_rdy [1:64];
  logic [15:0] q_dat [1:64];

  // idle pins at time zero
  initial begin
    chip_select_n   = 1'b1;
    address_valid_n = 1'b1;
    burst_clk       = 1'b0;
    address         = 24'h5a5a5a;
  end

  // one frame: latch edge, then k edges, each word taken before next edge
  task automatic run(input logic [23:0] a, input int k, input bit keep);
    int i;
    chip_select_n   = 1'b0;
    address_valid_n = 1'b0;
    address         = a;
    #16 burst_clk = 1'b1;
    #16 burst_clk = 1'b0;
    address_valid_n = 1'b1;
    address         = ~a; // released lines do not hold the old value
    for (i = 1; i <= k; i++) begin
      #16 burst_clk = 1'b1;
      #14 q_rdy[i] = ready;
      q_dat[i] = data_out;
      #2 burst_clk = 1'b0;
    end
    if (!keep) begin
      chip_select_n = 1'b1;
      #40;
    end
  endtask : run
endmodule : fbr_host_model

// file: tb/flash_burst_read_config_test.sv
/*
  self-checking bench for the burst engine: host model, array model,
  configuration writes and word-by-word burst checks.
  assumes the host model samples each word just before the next edge.
*/
`timescale 1ns/1ps

module flash_burst_read_config_test;
  logic        clock, rst_n, cfg_write, array_req, ready, async_mode;
  logic        chip_select_n, address_valid_n, burst_clk;
  logic [15:0] cfg_wdata, bank_busy, status_word, array_data;
  logic [15:0] data_out, cfg_rdata, c;
  logic [23:0] address, array_addr;
  logic        e_rdy [1:64];
  logic [15:0] e_dat [1:64];
  int          num_errors, n_checks, cycles, li, bi;
  logic [2:0]  len_code [4] = '{fbr_pkg::BL_CONT, fbr_pkg::BL_8,
                                fbr_pkg::BL_16, fbr_pkg::BL_32};

  fbr_burst_engine i_dut (
    .clock(clock), .rst_n(rst_n), .chip_select_n(chip_select_n),
    .address_valid_n(address_valid_n), .burst_clk(burst_clk),
    .address(address), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
    .bank_busy(bank_busy), .status_word(status_word),
    .array_data(array_data), .array_addr(array_addr),
    .array_req(array_req), .data_out(data_out), .ready(ready),
    .cfg_rdata(cfg_rdata), .async_mode(async_mode)
  );

  fbr_host_model i_host (
    .chip_select_n(chip_select_n), .address_valid_n(address_valid_n),
    .burst_clk(burst_clk), .address(address), .data_out(data_out),
    .ready(ready)
  );

  // core clock, 4 ns
  always #2 clock = ~clock;

  // array model: word valid one clock after the fetch address
  always @(posedge clock) array_data <= word_of(array_addr);

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end

  function automatic logic [15:0] word_of(input logic [23:0] a);
    return a[15:0] ^ {a[23:16], a[23:16]} ^ 16'h3c96;
  endfunction : word_of

  function automatic logic [15:0] cfg_of(input logic [2:0] lat,
                                          input logic w,
                                          input logic [2:0] len);
    return {2'b00, lat, fbr_pkg::CFG_RESET[10:4], w, len};
  endfunction : cfg_of

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // expected ready and data for edges 1..k of a burst from a
  task automatic build(input logic [23:0] a, input int k);
    int lat, len, n, i;
    logic [23:0] p;
    logic stat, gap, lin_wrap;
    lat = (c[13:11] == fbr_pkg::LAT_5) ? 5 :
          (c[13:11] == fbr_pkg::LAT_6) ? 6 : 7;
    len = (c[2:0] == fbr_pkg::BL_8) ? 8 : (c[2:0] == fbr_pkg::BL_16) ? 16 :
          (c[2:0] == fbr_pkg::BL_32) ? 32 : 0;
    lin_wrap = c[3] && len != 0;
    p = a;
    n = 0;
    stat = 1'b0;
    gap = 1'b0;
    for (i = 1; i <= k; i++) begin
      e_rdy[i] = 1'b0;
      e_dat[i] = status_word;
      if (c[15] || i < lat || (len != 0 && n == len)) e_rdy[i] = 1'b0;
      else if (stat) e_rdy[i] = 1'b1;
      else if (gap) gap = 1'b0;
      else if (bank_busy[p[23:20]]) begin
        stat = 1'b1;
        e_rdy[i] = 1'b1;
      end else begin
        e_rdy[i] = 1'b1;
        e_dat[i] = word_of(p);
        n++;
        p = lin_wrap ? 24'((p & ~(len - 1)) | ((p + 1) & (len - 1))) :
            24'(p + 1);
        gap = !lin_wrap && p[6:0] == 7'h00 && !bank_busy[p[23:20]];
      end
    end
  endtask : build

  task automatic set_cfg(input logic [15:0] w);
    c = w;
    cfg_wdata = w;
    cfg_write = 1'b1;
    @(posedge clock);
    #1 cfg_write = 1'b0;
    @(posedge clock);
    #1;
    check("cfg read", w, cfg_rdata);
    check("mode", {15'h0, w[15]}, {15'h0, async_mode});
  endtask : set_cfg

  task automatic burst(input logic [23:0] a, input int k, input bit keep);
    int i;
    build(a, k);
    i_host.run(a, k, keep);
    if (!keep) check("ready idle", 16'h0000, {15'h0, ready});
    for (i = 1; i <= k; i++) begin
      check("ready", {15'h0, e_rdy[i]}, {15'h0, i_host.q_rdy[i]});
      if (e_rdy[i]) check("data", e_dat[i], i_host.q_dat[i]);
    end
    @(posedge clock);
    #1;
    check("cfg kept", c, cfg_rdata);
  endtask : burst

  task automatic do_reset(input int n);
    rst_n = 1'b0;
    c = fbr_pkg::CFG_RESET;
    repeat (n) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check("cfg reset", fbr_pkg::CFG_RESET, cfg_rdata);
    check("async", 16'h0001, {15'h0, async_mode});
  endtask : do_reset

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // corner cases, then every latency and length code with random starts
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    cfg_write = 1'b0;
    cfg_wdata = 16'h0000;
    bank_busy = 16'h0000;
    status_word = 16'h5e17;
    array_data = 16'h0000;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(46844));
    do_reset(20);
    burst(24'h000010, 12, 1'b0);
    set_cfg(cfg_of(fbr_pkg::LAT_7, 1'b1, fbr_pkg::BL_8));
    burst(24'h00003c, 16, 1'b0);
    set_cfg(cfg_of(fbr_pkg::LAT_5, 1'b0, fbr_pkg::BL_8));
    burst(24'h00007c, 12, 1'b0);
    set_cfg(cfg_of(fbr_pkg::LAT_6, 1'b1, fbr_pkg::BL_32));
    burst(24'h00006f, 40, 1'b0);
    set_cfg(cfg_of(fbr_pkg::LAT_5, 1'b1, fbr_pkg::BL_CONT));
    burst(24'hfffffd, 20, 1'b0);
    burst(24'h123400, 12, 1'b1);
    burst(24'h45677e, 20, 1'b0);
    bank_busy = 16'h0004;
    burst(24'h1ffffc, 16, 1'b0);
    bank_busy = 16'h0000;
    burst(24'h200000, 12, 1'b0);
    for (li = 0; li < 3; li++) begin
      for (bi = 0; bi < 4; bi++) begin
        set_cfg(cfg_of(3'(fbr_pkg::LAT_5 + li), 1'($urandom),
                       len_code[bi]));
        burst(24'($urandom), 48, 1'b0);
      end
    end
    do_reset(3);
    burst(24'h000040, 12, 1'b0);
    finish_test();
  end
endmodule : flash_burst_read_config_test
